//--- src/trbc_pkg.sv
// Register map, field positions, reset values and mode codes of the reload/baud counter
package trbc_pkg;

  // Register addresses
  localparam logic [7:0] TRBC_ADDR_CTRL  = 8'hC8; // timer_control
  localparam logic [7:0] TRBC_ADDR_RCL   = 8'hCA; // reload_capture_low
  localparam logic [7:0] TRBC_ADDR_RCH   = 8'hCB; // reload_capture_high
  localparam logic [7:0] TRBC_ADDR_CNTL  = 8'hCC; // count_low
  localparam logic [7:0] TRBC_ADDR_CNTH  = 8'hCD; // count_high
  localparam logic [7:0] TRBC_ADDR_CLKC  = 8'hCE; // clock and interrupt control

  // timer_control fields
  localparam int unsigned TRBC_OVF_BIT   = 7;     // overflow_flag
  localparam int unsigned TRBC_EXF_BIT   = 6;     // external_edge_flag
  localparam int unsigned TRBC_RXSEL_BIT = 5;     // rx_baud_select
  localparam int unsigned TRBC_TXSEL_BIT = 4;     // tx_baud_select
  localparam int unsigned TRBC_EXEN_BIT  = 3;     // external_edge_enable
  localparam int unsigned TRBC_RUN_BIT   = 2;     // run_control
  localparam int unsigned TRBC_CSEL_BIT  = 1;     // counter_select
  localparam int unsigned TRBC_CPRL_BIT  = 0;     // capture_reload_select

  // Clock and interrupt control fields
  localparam int unsigned TRBC_PRESC_BIT = 0;     // prescale_select: 1 undivided, 0 by 12
  localparam int unsigned TRBC_IRQEN_BIT = 1;     // timer interrupt enable

  // Reset values
  localparam logic [7:0]  TRBC_CTRL_RST  = 8'h00;
  localparam logic [7:0]  TRBC_RC_RST    = 8'h00;
  localparam logic [7:0]  TRBC_CNT_RST   = 8'h00;
  localparam logic [7:0]  TRBC_CLKC_RST  = 8'h00;

  // Timing: system clock prescale ratio outside baud mode
  localparam logic [3:0]  TRBC_PRESCALE_DIV = 4'hC;

  // Pin index inside the edge interface
  localparam int unsigned TRBC_PIN_COUNT = 0;     // external_count_pin
  localparam int unsigned TRBC_PIN_TRIG  = 1;     // external_trigger_pin

  // Operating mode, one-hot
  typedef enum logic [3:0] {
    TRBC_OFF     = 4'h1,
    TRBC_CAPTURE = 4'h2,
    TRBC_RELOAD  = 4'h4,
    TRBC_BAUD    = 4'h8
  } trbc_mode_e;

endpackage

//--- src/trbc_edge_if.sv
// Falling-edge events passed from the pin synchroniser to the counter core
`timescale 1ns/1ps
`default_nettype none
interface trbc_edge_if;
  logic [1:0] fall;  // One-cycle falling-edge pulses, indexed by pin

  modport src (output fall);
  modport dst (input fall);
endinterface
`default_nettype wire

//--- src/trbc_fall_detect.sv
// Two-flop synchroniser and falling-edge detector for the external pins
`timescale 1ns/1ps
`default_nettype none
module trbc_fall_detect #(
  parameter int unsigned W = 2  // Number of pins
) (
  input  wire logic         clk_i,   // System clock
  input  wire logic         srst_i,  // Synchronous reset, active high
  input  wire logic [W-1:0] pins_i,  // Raw pin levels
  trbc_edge_if.src          evt      // Falling-edge pulses
);

  logic [W-1:0] meta_q;  // First stage, read only by second stage
  logic [W-1:0] sync_q;  // Settled level
  logic [W-1:0] prev_q;  // Level one cycle earlier

  // Reset to idle high so release never looks like a falling edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign evt.fall = prev_q & ~sync_q;

  // One pulse per falling edge
  property p_fall_single;
    @(posedge clk_i) disable iff (srst_i)
      |evt.fall |=> (evt.fall & $past(evt.fall)) == '0;
  endproperty
  a_fall_single: assert property (p_fall_single)
    else $error("falling-edge pulse lasted two cycles");

endmodule
`default_nettype wire

//--- src/trbc_tick_gen.sv
// Count tick source: system clock undivided, divided by twelve, or halved in baud mode
`timescale 1ns/1ps
`default_nettype none
module trbc_tick_gen #(
  parameter logic [3:0] PRESCALE_DIV = trbc_pkg::TRBC_PRESCALE_DIV  // Slow prescale ratio
) (
  input  wire logic clk_i,              // System clock
  input  wire logic srst_i,             // Synchronous reset, active high
  input  wire logic baud_mode_i,        // Baud generator configured
  input  wire logic prescale_select_i,  // 1 undivided, 0 divided
  output logic      tick_o              // One-cycle count enable
);

  logic [3:0] div_q;   // Prescale counter
  logic       half_q;  // Toggles every clock for the halved timebase

  // Free-running prescaler; phase is not reset by mode changes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= 4'h0;
    end else if (div_q == PRESCALE_DIV - 4'h1) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Halving toggle for baud mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  always_comb begin
    if (baud_mode_i) begin
      tick_o = half_q;
    end else if (prescale_select_i) begin
      tick_o = 1'b1;
    end else begin
      tick_o = (div_q == PRESCALE_DIV - 4'h1);
    end
  end

  property p_half_rate;
    @(posedge clk_i) disable iff (srst_i)
      baud_mode_i && tick_o |=> !tick_o || !baud_mode_i;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("baud timebase ticked on two adjacent clocks");

  property p_div_gap;
    @(posedge clk_i) disable iff (srst_i)
      (!baud_mode_i && !prescale_select_i && tick_o)
        ##1 (!baud_mode_i && !prescale_select_i) [*8] |-> !$past(tick_o) && !tick_o;
  endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("divided timebase ticked too early");

endmodule
`default_nettype wire

//--- src/trbc_top.sv
// Sixteen-bit reload, capture and baud-rate counter with its register port
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module trbc_top (
  input  wire logic       clk_i,                   // System clock, 125 MHz
  input  wire logic       srst_i,                  // Synchronous reset, active high
  input  wire logic [7:0] addr_i,                  // Register address
  input  wire logic [7:0] wdata_i,                 // Write data
  input  wire logic       wr_i,                    // Write strobe
  input  wire logic       rd_i,                    // Read strobe
  output logic      [7:0] rdata_o,                 // Read data, cycle after strobe
  input  wire logic       external_count_pin_i,    // External count input
  input  wire logic       external_trigger_pin_i,  // External trigger input
  input  wire logic       other_timer_ovf_i,       // Other timer overflow pulse
  output logic            rx_shift_tick_o,         // UART receive shift clock pulse
  output logic            tx_shift_tick_o,         // UART transmit shift clock pulse
  output logic            timer_irq_o              // Timer interrupt request, level
);

  // Register state
  logic [7:0]  ctrl_q;     // timer_control
  logic [7:0]  clkc_q;     // Prescale and interrupt enable
  logic [15:0] rc_q;       // reload_capture pair
  logic [15:0] count_q;    // count pair
  logic [7:0]  rdata_q;    // Read data hold
  logic        rx_tick_q;  // Registered receive shift pulse
  logic        tx_tick_q;  // Registered transmit shift pulse
  logic        irq_q;      // Registered interrupt request

  // Decoded controls
  logic rx_sel;     // rx_baud_select
  logic tx_sel;     // tx_baud_select
  logic ext_en;     // external_edge_enable
  logic run;        // run_control
  logic cnt_sel;    // counter_select
  logic cap_sel;    // capture_reload_select
  logic cfg_baud;   // Baud generator configured
  logic cfg_cap;    // Capture configured
  logic presc_sel;  // prescale_select
  logic irq_en;     // Timer interrupt enable

  // Register port decode
  logic wr_ctrl;    // Write to timer_control
  logic wr_clkc;    // Write to clock and interrupt control
  logic wr_rcl;     // Write to reload_capture_low
  logic wr_rch;     // Write to reload_capture_high
  logic wr_cntl;    // Write to count_low
  logic wr_cnth;    // Write to count_high

  // Counter events
  logic                 tick;       // Timebase tick from the prescaler
  logic                 cnt_fall;   // Synchronised fall on the count pin
  logic                 trig_fall;  // Synchronised fall on the trigger pin
  logic                 step;       // Count advances this cycle
  logic                 roll;       // Count rolls over from all ones
  logic                 trig;       // Enabled trigger event
  logic                 ovf_set;    // Hardware sets overflow_flag
  logic                 baud_roll;  // Rollover feeding the UART shift clocks
  logic [15:0]          roll_val;   // Value loaded on rollover
  trbc_pkg::trbc_mode_e mode;       // Current operating mode

  // Falling-edge events from the pin synchroniser
  trbc_edge_if edge_bus ();

  // Control field decode
  assign rx_sel    = ctrl_q[trbc_pkg::TRBC_RXSEL_BIT];
  assign tx_sel    = ctrl_q[trbc_pkg::TRBC_TXSEL_BIT];
  assign ext_en    = ctrl_q[trbc_pkg::TRBC_EXEN_BIT];
  assign run       = ctrl_q[trbc_pkg::TRBC_RUN_BIT];
  assign cnt_sel   = ctrl_q[trbc_pkg::TRBC_CSEL_BIT];
  assign cap_sel   = ctrl_q[trbc_pkg::TRBC_CPRL_BIT];
  assign presc_sel = clkc_q[trbc_pkg::TRBC_PRESC_BIT];
  assign irq_en    = clkc_q[trbc_pkg::TRBC_IRQEN_BIT];

  // baud overrides capture
  // Either baud select wins over the capture select bit
  assign cfg_baud = rx_sel | tx_sel;
  assign cfg_cap  = cap_sel & ~cfg_baud;

  // Write strobes per register; the slave never stalls the master
  assign wr_ctrl = wr_i && (addr_i == trbc_pkg::TRBC_ADDR_CTRL);
  assign wr_clkc = wr_i && (addr_i == trbc_pkg::TRBC_ADDR_CLKC);
  assign wr_rcl  = wr_i && (addr_i == trbc_pkg::TRBC_ADDR_RCL);
  assign wr_rch  = wr_i && (addr_i == trbc_pkg::TRBC_ADDR_RCH);
  assign wr_cntl = wr_i && (addr_i == trbc_pkg::TRBC_ADDR_CNTL);
  assign wr_cnth = wr_i && (addr_i == trbc_pkg::TRBC_ADDR_CNTH);

  // pins synchronised first
  // Index order follows the package pin positions
  trbc_fall_detect #(
    .W (2)
  ) fall_u (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pins_i ({external_trigger_pin_i, external_count_pin_i}),
    .evt    (edge_bus)
  );

  // Synchronised edge pulses, one cycle each
  assign cnt_fall  = edge_bus.fall[trbc_pkg::TRBC_PIN_COUNT];
  assign trig_fall = edge_bus.fall[trbc_pkg::TRBC_PIN_TRIG];

  // prescaled timebase
  // The tick source halves the clock in baud mode
  trbc_tick_gen #(
    .PRESCALE_DIV (trbc_pkg::TRBC_PRESCALE_DIV)
  ) tick_u (
    .clk_i             (clk_i),
    .srst_i            (srst_i),
    .baud_mode_i       (cfg_baud),
    .prescale_select_i (presc_sel),
    .tick_o            (tick)
  );

  // mode decode
  // Run low means off; baud beats capture, capture beats reload
  always_comb begin
    if (!run) begin
      mode = trbc_pkg::TRBC_OFF;
    end else if (cfg_baud) begin
      mode = trbc_pkg::TRBC_BAUD;
    end else if (cap_sel) begin
      mode = trbc_pkg::TRBC_CAPTURE;
    end else begin
      mode = trbc_pkg::TRBC_RELOAD;
    end
  end

  // baud pin timebase
  // Pin edges come two clocks late through the synchroniser
  assign step = run && (cnt_sel ? cnt_fall : tick);

  assign roll = step && (count_q == 16'hFFFF);

  // edge flag only from enabled fall
  // The trigger acts even while the run bit is low
  assign trig = ext_en && trig_fall;

  // pair supplies the reload value
  // Capture mode wraps to zero instead of reloading
  always_comb begin
    roll_val  = count_q;
    ovf_set   = 1'b0;
    baud_roll = 1'b0;
    unique case (mode)
      trbc_pkg::TRBC_OFF: begin
        // No rollover can happen while stopped
        roll_val = count_q;
      end
      trbc_pkg::TRBC_CAPTURE: begin
        roll_val = 16'h0000;
        ovf_set  = roll;
      end
      trbc_pkg::TRBC_RELOAD: begin
        roll_val = rc_q;
        ovf_set  = roll;
      end
      trbc_pkg::TRBC_BAUD: begin
        roll_val  = rc_q;
        baud_roll = roll;
      end
    endcase
  end

  // baud trigger leaves count alone
  // Software byte writes land last, so they win over counting
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_q <= {trbc_pkg::TRBC_CNT_RST, trbc_pkg::TRBC_CNT_RST};
    end else begin
      if (trig && !cfg_baud && !cfg_cap) begin
        count_q <= rc_q;
      end else if (roll) begin
        count_q <= roll_val;
      end else if (step) begin
        count_q <= count_q + 16'h0001;
      end
      if (wr_cntl) begin
        count_q[7:0] <= wdata_i;
      end
      if (wr_cnth) begin
        count_q[15:8] <= wdata_i;
      end
    end
  end

  // capture copies count
  // A capture in the same cycle as a software write wins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rc_q <= {trbc_pkg::TRBC_RC_RST, trbc_pkg::TRBC_RC_RST};
    end else begin
      if (wr_rcl) begin
        rc_q[7:0] <= wdata_i;
      end
      if (wr_rch) begin
        rc_q[15:8] <= wdata_i;
      end
      if (trig && cfg_cap) begin
        rc_q <= count_q;
      end
    end
  end

  // flags stick until cleared
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= trbc_pkg::TRBC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_i;
      end
      if (ovf_set) begin
        ctrl_q[trbc_pkg::TRBC_OVF_BIT] <= 1'b1;
      end
      if (trig) begin
        ctrl_q[trbc_pkg::TRBC_EXF_BIT] <= 1'b1;
      end
    end
  end

  // Clock and interrupt control, plain software register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clkc_q <= trbc_pkg::TRBC_CLKC_RST;
    end else if (wr_clkc) begin
      clkc_q <= wdata_i;
    end
  end

  // either flag requests interrupt
  // Registered, so the request trails the flag by one clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en && (ctrl_q[trbc_pkg::TRBC_OVF_BIT] || ctrl_q[trbc_pkg::TRBC_EXF_BIT]);
    end
  end

  // shift clock routing
  // A clear select hands that direction to the other timer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= rx_sel ? baud_roll : other_timer_ovf_i;
      tx_tick_q <= tx_sel ? baud_roll : other_timer_ovf_i;
    end
  end

  // register read port
  // Data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        trbc_pkg::TRBC_ADDR_CTRL: begin
          rdata_q <= ctrl_q;
        end
        trbc_pkg::TRBC_ADDR_CLKC: begin
          rdata_q <= clkc_q;
        end
        trbc_pkg::TRBC_ADDR_RCL: begin
          rdata_q <= rc_q[7:0];
        end
        trbc_pkg::TRBC_ADDR_RCH: begin
          rdata_q <= rc_q[15:8];
        end
        trbc_pkg::TRBC_ADDR_CNTL: begin
          rdata_q <= count_q[7:0];
        end
        trbc_pkg::TRBC_ADDR_CNTH: begin
          rdata_q <= count_q[15:8];
        end
        default: begin
          // Unmapped addresses read as zero
          rdata_q <= 8'h00;
        end
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o         = rdata_q;
  assign rx_shift_tick_o = rx_tick_q;
  assign tx_shift_tick_o = tx_tick_q;
  assign timer_irq_o     = irq_q;

  // Rollover outside capture with no competing write
  sequence s_reload_roll;
    roll && (mode != trbc_pkg::TRBC_CAPTURE) && !trig && !wr_i;
  endsequence

  // Enabled trigger in reload configuration with no competing write
  sequence s_trig_reload;
    trig && !cfg_baud && !cfg_cap && !wr_i;
  endsequence

  property p_roll_reload;
    @(posedge clk_i) disable iff (srst_i)
      s_reload_roll |=> count_q == $past(rc_q);
  endproperty
  a_roll_reload: assert property (p_roll_reload)
    else $error("rollover did not load the reload pair");

  property p_roll_flag;
    @(posedge clk_i) disable iff (srst_i)
      roll && (mode == trbc_pkg::TRBC_RELOAD) |=> ctrl_q[trbc_pkg::TRBC_OVF_BIT];
  endproperty
  a_roll_flag: assert property (p_roll_flag)
    else $error("rollover did not set the overflow flag");

  property p_trig_reload;
    @(posedge clk_i) disable iff (srst_i)
      s_trig_reload |=> (count_q == $past(rc_q)) && ctrl_q[trbc_pkg::TRBC_EXF_BIT];
  endproperty
  a_trig_reload: assert property (p_trig_reload)
    else $error("trigger did not force a reload");

  property p_baud_quiet;
    @(posedge clk_i) disable iff (srst_i)
      cfg_baud && !wr_ctrl |=> ctrl_q[trbc_pkg::TRBC_OVF_BIT] == $past(ctrl_q[trbc_pkg::TRBC_OVF_BIT]);
  endproperty
  a_baud_quiet: assert property (p_baud_quiet)
    else $error("overflow flag moved in baud mode");

  property p_edge_ignored;
    @(posedge clk_i) disable iff (srst_i)
      !ext_en && !wr_ctrl |=> ctrl_q[trbc_pkg::TRBC_EXF_BIT] == $past(ctrl_q[trbc_pkg::TRBC_EXF_BIT]);
  endproperty
  a_edge_ignored: assert property (p_edge_ignored)
    else $error("edge flag moved with edge enable clear");

  property p_irq_level;
    @(posedge clk_i) disable iff (srst_i)
      1'b1 |=> irq_q == $past(irq_en && (ctrl_q[trbc_pkg::TRBC_OVF_BIT] || ctrl_q[trbc_pkg::TRBC_EXF_BIT]));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt request does not follow the flags");

endmodule
`default_nettype wire

//--- verif/trbc_far_model.sv
// Far-side model: external pins and the UART shift-clock pulse counters
`timescale 1ns/1ps
`default_nettype none
module trbc_far_model (
  input  wire logic clk_i,      // System clock
  input  wire logic rx_tick_i,  // UART receive shift pulse
  input  wire logic tx_tick_i,  // UART transmit shift pulse
  output logic      cnt_pin_o,  // Count pin, idles high
  output logic      trg_pin_o,  // Trigger pin, idles high
  output logic      oth_ovf_o   // Other timer overflow, one clock in ten
);
  int rx_n = 0;  // Receive pulses seen
  int tx_n = 0;  // Transmit pulses seen
  int ph   = 0;  // Other timer phase
  initial begin
    cnt_pin_o = 1'b1;
    trg_pin_o = 1'b1;
    oth_ovf_o = 1'b0;
  end
  // Count pulses and free-run the other timer so routing can be told apart
  always @(posedge clk_i) begin
    rx_n      <= rx_n + int'(rx_tick_i);
    tx_n      <= tx_n + int'(tx_tick_i);
    ph        <= (ph == 9) ? 0 : ph + 1;
    oth_ovf_o <= (ph == 9);
  end
  // One falling edge; each level held four clocks so the synchroniser sees it
  task automatic fall(input bit trg);
    @(posedge clk_i);
    if (trg) trg_pin_o <= 1'b0;
    else cnt_pin_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    trg_pin_o <= 1'b1;
    cnt_pin_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the reload, capture and baud counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;  // Bus strobes
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, r;          // Bus data
  logic       cnt_pin, trg_pin, oth_ovf, rx_tick, tx_tick, irq;     // Far side
  int         err_total = 0, comparisons = 0, a, b;                 // Tallies
  logic [7:0] ra [5] = '{trbc_pkg::TRBC_ADDR_CTRL, trbc_pkg::TRBC_ADDR_RCL,
    trbc_pkg::TRBC_ADDR_RCH, trbc_pkg::TRBC_ADDR_CNTL, trbc_pkg::TRBC_ADDR_CNTH};
  always #4 clk_i = ~clk_i;
  trbc_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_count_pin_i(cnt_pin),
    .external_trigger_pin_i(trg_pin), .other_timer_ovf_i(oth_ovf),
    .rx_shift_tick_o(rx_tick), .tx_shift_tick_o(tx_tick), .timer_irq_o(irq));
  trbc_far_model pm_u (.clk_i(clk_i), .rx_tick_i(rx_tick), .tx_tick_i(tx_tick),
    .cnt_pin_o(cnt_pin), .trg_pin_o(trg_pin), .oth_ovf_o(oth_ovf));
  // One-cycle write
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= ad;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // One-cycle read; data is valid only in the following cycle
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  task automatic ld(input logic [15:0] rl, input logic [15:0] cn);
    wr(ra[1], rl[7:0]);
    wr(ra[2], rl[15:8]);
    wr(ra[3], cn[7:0]);
    wr(ra[4], cn[15:8]);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog far beyond the thousand or so clocks the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      cmp8(r, 8'h00);
    end
    $display("test reset done");
    wr(trbc_pkg::TRBC_ADDR_CLKC, 8'h03);
    ld(16'hFFF0, 16'hFFFE);
    wr(ra[0], 8'h04);
    repeat (6) @(posedge clk_i);
    rd(ra[0]);
    cmp8(r, 8'h84);
    cmp1(irq, 1'b1);
    rd(ra[4]);
    cmp8(r, 8'hFF);
    wr(ra[0], 8'h00);
    rd(ra[0]);
    cmp8(r, 8'h00);
    cmp1(irq, 1'b0);
    $display("test reload done");
    ld(16'h5678, 16'h1234);
    pm_u.fall(1'b1);
    rd(ra[0]);
    cmp8(r, 8'h00);
    rd(ra[3]);
    cmp8(r, 8'h34);
    wr(ra[0], 8'h08);
    pm_u.fall(1'b1);
    rd(ra[0]);
    cmp8(r, 8'h48);
    rd(ra[3]);
    cmp8(r, 8'h78);
    wr(ra[0], 8'h09);
    wr(ra[3], 8'hA5);
    pm_u.fall(1'b1);
    rd(ra[1]);
    cmp8(r, 8'hA5);
    rd(ra[2]);
    cmp8(r, 8'h56);
    wr(ra[0], 8'h06);
    wr(ra[3], 8'h00);
    repeat (3) pm_u.fall(1'b0);
    rd(ra[3]);
    cmp8(r, 8'h03);
    $display("test edges done");
    ld(16'hFFFE, 16'hFFFE);
    a = pm_u.rx_n;
    b = pm_u.tx_n;
    wr(ra[0], 8'h34);
    repeat (400) @(posedge clk_i);
    cmp1((pm_u.rx_n - a) inside {[99:101]}, 1'b1);
    cmp1((pm_u.tx_n - b) inside {[99:101]}, 1'b1);
    rd(ra[0]);
    cmp8(r, 8'h34);
    a = pm_u.rx_n;
    b = pm_u.tx_n;
    wr(ra[0], 8'h15);
    repeat (400) @(posedge clk_i);
    cmp1((pm_u.rx_n - a) inside {[39:41]}, 1'b1);
    cmp1((pm_u.tx_n - b) inside {[99:101]}, 1'b1);
    wr(ra[0], 8'h1C);
    pm_u.fall(1'b1);
    rd(ra[0]);
    cmp8(r, 8'h5C);
    $display("test baud done");
    final_report();
  end
endmodule
`default_nettype wire
